/* File: hw/pfpc_pkg.sv */
// package of shared constants for the parallel flash programming link
package pfpc_pkg;
   // bus and storage geometry
   localparam int DATA_W_DEF = 16;
   localparam int ADDR_W_DEF = 32;
   localparam int NLOCK_DEF = 16;
   localparam int NGPB_DEF = 3;
   localparam int REGION_SHIFT_DEF = 14;
   localparam int NCTL = 2;
   localparam int CMD_W = 8;
   // mode field codes on the mode bus
   localparam logic [3:0] MODE_CMD = 4'h1;
   localparam logic [3:0] MODE_ADDR = 4'h2;
   localparam logic [3:0] MODE_DATA = 4'h6;
   // command opcodes
   localparam logic [CMD_W-1:0] OP_NONE = 8'h00;
   localparam logic [CMD_W-1:0] OP_WP = 8'h11;
   localparam logic [CMD_W-1:0] OP_WLK = 8'h12;
   localparam logic [CMD_W-1:0] OP_EWP = 8'h13;
   localparam logic [CMD_W-1:0] OP_EWLK = 8'h14;
   localparam logic [CMD_W-1:0] OP_ERA = 8'h19;
   localparam logic [CMD_W-1:0] OP_SLK = 8'h21;
   localparam logic [CMD_W-1:0] OP_ULK = 8'h22;
   localparam logic [CMD_W-1:0] OP_RLK = 8'h23;
   localparam logic [CMD_W-1:0] OP_GPST = 8'h24;
   localparam logic [CMD_W-1:0] OP_GPCL = 8'h25;
   localparam logic [CMD_W-1:0] OP_GPRD = 8'h26;
   localparam logic [CMD_W-1:0] OP_SEC = 8'h27;
   localparam logic [CMD_W-1:0] OP_CSEL = 8'h34;
   localparam logic [CMD_W-1:0] OP_MEMW = 8'h1F;
   localparam logic [CMD_W-1:0] OP_VER = 8'h1E;
   // arbitrary version word
   localparam logic [15:0] VERSION_DEF = 16'h0A5C;
   // timing
   localparam int CLK_HZ = 125_000_000;
   localparam int ERASE_HOLD_MS = 220;
   localparam int ERASE_HOLD_CYC = ERASE_HOLD_MS * (CLK_HZ / 1000);
   localparam int TIMEOUT_CYC_DEF = 1024;
endpackage : pfpc_pkg

/* File: hw/pfpc_if.sv */
// interface joining the device end and the programmer end
interface pfpc_if #(
   parameter int DATA_W = pfpc_pkg::DATA_W_DEF
);
   logic ncmd; // command strobe, low active
   logic noe; // read output enable, low active
   logic [3:0] mode; // phase code
   logic [DATA_W-1:0] prog_data; // programmer data out
   logic prog_data_oe; // programmer drives data
   logic rdy; // device ready, high when idle
   logic nvalid; // read data valid, low active
   logic [DATA_W-1:0] dev_data; // device data out
   logic dev_data_oe; // device drives data
   logic [DATA_W-1:0] data; // resolved data wire
   // resolve the shared bus from the two enables
   assign data = prog_data_oe ? prog_data :
                 (dev_data_oe ? dev_data : '0);
   modport dev (
      input ncmd, noe, mode, data,
      output rdy, nvalid, dev_data, dev_data_oe
   );
   modport prog (
      input rdy, nvalid, data,
      output ncmd, noe, mode, prog_data, prog_data_oe
   );
endinterface : pfpc_if

/* File: hw/pfpc_dev.sv */
// device end: command interpreter of the fast programming port
module pfpc_dev #(
   parameter int DATA_W = pfpc_pkg::DATA_W_DEF,
   parameter int ADDR_W = pfpc_pkg::ADDR_W_DEF,
   parameter int NLOCK = pfpc_pkg::NLOCK_DEF,
   parameter int NGPB = pfpc_pkg::NGPB_DEF,
   parameter int REGION_SHIFT = pfpc_pkg::REGION_SHIFT_DEF,
   parameter int ERASE_HOLD_CYC = pfpc_pkg::ERASE_HOLD_CYC,
   parameter logic [DATA_W-1:0] VERSION = DATA_W'(pfpc_pkg::VERSION_DEF)
)(
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset, high
   pfpc_if.dev link, // programmer link
   input wire logic erase_pin, // erase pin, high active
   input wire logic test_mode_input, // test mode pin
   output logic mem_wr, // one-cycle write strobe
   output logic mem_wr_flash, // strobe targets flash page buffer
   output logic [ADDR_W-1:0] mem_addr, // write address
   output logic [DATA_W-1:0] mem_wdata, // write data
   output logic page_flush, // pulse: flush page buffer
   output logic erase_all, // pulse: erase selected plane
   output logic erase_abort, // pulse: erase refused, locked
   output logic sel_ctl, // selected controller
   output logic secured, // security bit
   output logic [pfpc_pkg::NCTL-1:0][NLOCK-1:0] lock_bits, // lock bits
   output logic [pfpc_pkg::NCTL-1:0][NGPB-1:0] gp_bits // gp bits
);
   localparam int NADDR = ADDR_W / DATA_W;
   localparam int LIDX_W = $clog2(NLOCK);

   typedef enum logic [2:0] {
      PFPC_IDLE, PFPC_WAIT_NOE, PFPC_DRIVE, PFPC_WAIT_NOEH, PFPC_WAIT_REL
   } pfpc_dev_state_e;

   // true for commands whose data phase is a read
   function automatic logic is_read(input logic [pfpc_pkg::CMD_W-1:0] c);
      is_read = (c == pfpc_pkg::OP_RLK) || (c == pfpc_pkg::OP_GPRD) ||
                (c == pfpc_pkg::OP_VER);
   endfunction : is_read

   // true for page write commands that load the flash buffer
   function automatic logic is_page(input logic [pfpc_pkg::CMD_W-1:0] c);
      is_page = (c == pfpc_pkg::OP_WP) || (c == pfpc_pkg::OP_WLK) ||
                (c == pfpc_pkg::OP_EWP) || (c == pfpc_pkg::OP_EWLK);
   endfunction : is_page

   logic ncmd_s1_ff, ncmd_s2_ff; // strobe synchroniser
   logic noe_s1_ff, noe_s2_ff; // output enable synchroniser
   logic erase_s1_ff, erase_s2_ff; // erase pin synchroniser
   logic tmd_s1_ff, tmd_s2_ff; // test pin synchroniser
   pfpc_dev_state_e state_ff; // handshake state
   logic rdy_ff, nvalid_ff, doe_ff; // link outputs
   logic [DATA_W-1:0] dout_ff; // read data driven on link
   logic [DATA_W-1:0] rd_data_ff; // answer prepared for read
   logic [pfpc_pkg::CMD_W-1:0] cmd_ff; // current command
   logic [ADDR_W-1:0] addr_ff; // internal address pointer
   logic [ADDR_W-1:0] last_addr_ff; // last page or memory write address
   logic pend_ff; // page buffer holds unflushed data
   logic sel_ff; // selected controller
   logic secure_ff; // security bit
   logic [pfpc_pkg::NCTL-1:0][NLOCK-1:0] lock_ff; // lock bits
   logic [pfpc_pkg::NCTL-1:0][NGPB-1:0] gp_ff; // gp bits
   logic wr_ff, wr_flash_ff, flush_ff, er_ff, abort_ff; // pulses, except wr_flash_ff which holds between writes
   logic [ADDR_W-1:0] wr_addr_ff; // write address out
   logic [DATA_W-1:0] wr_data_ff; // write data out
   logic [31:0] ecnt_ff; // erase pin hold counter

   logic take, is_cmd, is_dat, dat_zero, locked, er_ok, d_er, fire;
   logic flush_lock;
   logic [NLOCK-1:0] region_hot;
   logic [LIDX_W-1:0] region_idx;

   // two-flop synchronisers for the pins
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         {ncmd_s1_ff, ncmd_s2_ff, noe_s1_ff, noe_s2_ff} <= 4'hF;
         {erase_s1_ff, erase_s2_ff, tmd_s1_ff, tmd_s2_ff} <= 4'h0;
      end
      else
      begin
         ncmd_s1_ff <= link.ncmd;
         ncmd_s2_ff <= ncmd_s1_ff;
         noe_s1_ff <= link.noe;
         noe_s2_ff <= noe_s1_ff;
         erase_s1_ff <= erase_pin;
         erase_s2_ff <= erase_s1_ff;
         tmd_s1_ff <= test_mode_input;
         tmd_s2_ff <= tmd_s1_ff;
      end
   end

   // decode of the phase being latched this cycle
   always_comb
   begin
      take = (state_ff == PFPC_IDLE) && !ncmd_s2_ff && !secure_ff;
      is_cmd = take && (link.mode == pfpc_pkg::MODE_CMD);
      is_dat = take && (link.mode == pfpc_pkg::MODE_DATA);
      dat_zero = (link.data == '0);
      locked = |lock_ff[sel_ff];
      d_er = is_dat && (cmd_ff == pfpc_pkg::OP_ERA) && dat_zero;
      er_ok = d_er && !locked;
      flush_lock = is_cmd && pend_ff && ((cmd_ff == pfpc_pkg::OP_WLK) ||
                   (cmd_ff == pfpc_pkg::OP_EWLK));
      region_idx = LIDX_W'(last_addr_ff >> REGION_SHIFT);
      region_hot = NLOCK'(1) << region_idx;
      fire = erase_s2_ff && !tmd_s2_ff &&
             (ecnt_ff == 32'(ERASE_HOLD_CYC));
   end

   // link handshake sequencer
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_ff <= PFPC_IDLE;
         rdy_ff <= 1'b1;
         nvalid_ff <= 1'b1;
         doe_ff <= 1'b0;
         dout_ff <= '0;
      end
      else
      begin
         case (state_ff)
            PFPC_IDLE:
               // phase latched, drop ready
               if (take)
               begin
                  rdy_ff <= 1'b0;
                  if (is_dat && is_read(cmd_ff))
                     state_ff <= PFPC_WAIT_NOE;
                  else
                     state_ff <= PFPC_WAIT_REL;
               end
            PFPC_WAIT_NOE:
               // programmer released the bus and asked for data
               if (!noe_s2_ff)
               begin
                  doe_ff <= 1'b1;
                  dout_ff <= rd_data_ff;
                  state_ff <= PFPC_DRIVE;
               end
               else if (ncmd_s2_ff)
               begin
                  rdy_ff <= 1'b1;
                  state_ff <= PFPC_IDLE;
               end
            PFPC_DRIVE:
            begin
               // data settled one cycle before valid falls
               nvalid_ff <= 1'b0;
               state_ff <= PFPC_WAIT_NOEH;
            end
            PFPC_WAIT_NOEH:
               // programmer has read, release the bus
               if (noe_s2_ff)
               begin
                  doe_ff <= 1'b0;
                  nvalid_ff <= 1'b1;
                  state_ff <= PFPC_WAIT_REL;
               end
            PFPC_WAIT_REL:
               // end of handshake once strobe rises
               if (ncmd_s2_ff)
               begin
                  rdy_ff <= 1'b1;
                  state_ff <= PFPC_IDLE;
               end
            default:
               state_ff <= PFPC_IDLE;
         endcase
      end
   end

   // command, address and write stream
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cmd_ff <= pfpc_pkg::OP_NONE;
         addr_ff <= '0;
         last_addr_ff <= '0;
         pend_ff <= 1'b0;
         sel_ff <= 1'b0;
         wr_ff <= 1'b0;
         wr_flash_ff <= 1'b0;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
         flush_ff <= 1'b0;
         er_ff <= 1'b0;
         abort_ff <= 1'b0;
         rd_data_ff <= '0;
      end
      else
      begin
         wr_ff <= 1'b0;
         flush_ff <= 1'b0;
         er_ff <= er_ok || fire;
         abort_ff <= d_er && locked;
         // new command completes the previous one
         if (is_cmd)
         begin
            cmd_ff <= link.data[pfpc_pkg::CMD_W-1:0];
            flush_ff <= pend_ff;
            pend_ff <= 1'b0;
         end
         // address phases fill the pointer low part first
         for (int i = 0; i < NADDR; i++)
            if (take && (link.mode == pfpc_pkg::MODE_ADDR + 4'(i)))
               addr_ff[i*DATA_W +: DATA_W] <= link.data;
         // chained data words, pointer advances after each
         if (is_dat && (is_page(cmd_ff) || cmd_ff == pfpc_pkg::OP_MEMW))
         begin
            wr_ff <= 1'b1;
            wr_flash_ff <= is_page(cmd_ff);
            wr_addr_ff <= addr_ff;
            wr_data_ff <= link.data;
            addr_ff <= addr_ff + ADDR_W'(1);
            last_addr_ff <= addr_ff;
            pend_ff <= is_page(cmd_ff);
         end
         // controller select takes only zero or one
         if (is_dat && (cmd_ff == pfpc_pkg::OP_CSEL) &&
             (link.data[DATA_W-1:1] == '0))
            sel_ff <= link.data[0];
         // answer for read commands
         if (is_dat)
            case (cmd_ff)
               pfpc_pkg::OP_RLK: rd_data_ff <= DATA_W'(lock_ff[sel_ff]);
               pfpc_pkg::OP_GPRD: rd_data_ff <= DATA_W'(gp_ff[sel_ff]);
               pfpc_pkg::OP_VER: rd_data_ff <= VERSION;
               default: rd_data_ff <= rd_data_ff;
            endcase
      end
   end

   // nonvolatile lock, gp and security bits
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         lock_ff <= '0;
         gp_ff <= '0;
         secure_ff <= 1'b0;
      end
      else if (fire)
      begin
         // erase pin wipes the memory and the security bit
         lock_ff <= '0;
         gp_ff <= '0;
         secure_ff <= 1'b0;
      end
      else
      begin
         if (flush_lock)
            lock_ff[sel_ff] <= lock_ff[sel_ff] | region_hot;
         if (is_dat)
            case (cmd_ff)
               pfpc_pkg::OP_SLK:
                  lock_ff[sel_ff] <= lock_ff[sel_ff] |
                                     link.data[NLOCK-1:0];
               pfpc_pkg::OP_ULK:
                  lock_ff[sel_ff] <= lock_ff[sel_ff] &
                                     ~link.data[NLOCK-1:0];
               pfpc_pkg::OP_GPST:
                  gp_ff[sel_ff] <= gp_ff[sel_ff] |
                                   link.data[NGPB-1:0];
               pfpc_pkg::OP_GPCL:
                  gp_ff[sel_ff] <= gp_ff[sel_ff] &
                                   ~link.data[NGPB-1:0];
               pfpc_pkg::OP_ERA:
                  if (er_ok)
                  begin
                     lock_ff[sel_ff] <= '0;
                     gp_ff[sel_ff] <= '0;
                  end
               pfpc_pkg::OP_SEC:
                  if (dat_zero && !sel_ff)
                     secure_ff <= 1'b1;
               default:
                  secure_ff <= secure_ff;
            endcase
      end
   end

   // erase pin hold timer, counts only with test mode low
   always_ff @(posedge clock)
   begin
      if (srst)
         ecnt_ff <= '0;
      else if (erase_s2_ff && !tmd_s2_ff)
      begin
         if (ecnt_ff != 32'(ERASE_HOLD_CYC) + 32'h1)
            ecnt_ff <= ecnt_ff + 32'h1;
      end
      else
         ecnt_ff <= '0;
   end

   assign link.rdy = rdy_ff;
   assign link.nvalid = nvalid_ff;
   assign link.dev_data = dout_ff;
   assign link.dev_data_oe = doe_ff;
   assign mem_wr = wr_ff;
   assign mem_wr_flash = wr_flash_ff;
   assign mem_addr = wr_addr_ff;
   assign mem_wdata = wr_data_ff;
   assign page_flush = flush_ff;
   assign erase_all = er_ff;
   assign erase_abort = abort_ff;
   assign sel_ctl = sel_ff;
   assign secured = secure_ff;
   assign lock_bits = lock_ff;
   assign gp_bits = gp_ff;
endmodule : pfpc_dev

/* File: hw/pfpc_prog.sv */
// programmer end: runs one read or write handshake per request
module pfpc_prog #(
   parameter int DATA_W = pfpc_pkg::DATA_W_DEF,
   parameter int TIMEOUT_CYC = pfpc_pkg::TIMEOUT_CYC_DEF
)(
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset, high
   pfpc_if.prog link, // device link
   input wire logic req_valid, // request present
   input wire logic req_read, // request is a read handshake
   input wire logic [3:0] req_mode, // phase code
   input wire logic [DATA_W-1:0] req_data, // write value
   output logic req_ready, // idle, request taken when valid
   output logic rsp_done, // pulse: handshake finished
   output logic rsp_timeout, // with done: device never answered
   output logic [DATA_W-1:0] rsp_data // read value
);
   typedef enum logic [2:0] {
      PFPC_P_IDLE, PFPC_P_SETUP, PFPC_P_WAIT_RDYL, PFPC_P_NOE,
      PFPC_P_WAIT_NVL, PFPC_P_WAIT_NVH, PFPC_P_NCMD_HI, PFPC_P_WAIT_RDYH
   } pfpc_prog_state_e;

   pfpc_prog_state_e state_ff; // sequencer state
   logic rdy_s1_ff, rdy_s2_ff; // ready synchroniser
   logic nv_s1_ff, nv_s2_ff; // valid synchroniser
   logic ncmd_ff, noe_ff, oe_ff; // link outputs
   logic [3:0] mode_ff; // phase code out
   logic [DATA_W-1:0] pdata_ff; // data out
   logic rd_ff; // current request is a read
   logic ready_ff, done_ff, tmo_ff; // user outputs
   logic [DATA_W-1:0] rsp_ff; // captured read data
   logic [31:0] tcnt_ff; // wait-for-device counter

   // two-flop synchronisers for device outputs
   always_ff @(posedge clock)
   begin
      if (srst)
         {rdy_s1_ff, rdy_s2_ff, nv_s1_ff, nv_s2_ff} <= 4'hF;
      else
      begin
         rdy_s1_ff <= link.rdy;
         rdy_s2_ff <= rdy_s1_ff;
         nv_s1_ff <= link.nvalid;
         nv_s2_ff <= nv_s1_ff;
      end
   end

   // handshake sequencer, one request per handshake
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_ff <= PFPC_P_IDLE;
         ncmd_ff <= 1'b1;
         noe_ff <= 1'b1;
         oe_ff <= 1'b1;
         mode_ff <= '0;
         pdata_ff <= '0;
         rd_ff <= 1'b0;
         ready_ff <= 1'b0;
         done_ff <= 1'b0;
         tmo_ff <= 1'b0;
         rsp_ff <= '0;
         tcnt_ff <= '0;
      end
      else
      begin
         done_ff <= 1'b0;
         case (state_ff)
            PFPC_P_IDLE:
            begin
               ready_ff <= rdy_s2_ff;
               // set mode and data before the strobe falls
               if (req_valid && ready_ff && rdy_s2_ff)
               begin
                  mode_ff <= req_mode;
                  pdata_ff <= req_data;
                  rd_ff <= req_read;
                  oe_ff <= 1'b1;
                  ready_ff <= 1'b0;
                  tmo_ff <= 1'b0;
                  state_ff <= PFPC_P_SETUP;
               end
            end
            PFPC_P_SETUP:
            begin
               ncmd_ff <= 1'b0;
               tcnt_ff <= '0;
               state_ff <= PFPC_P_WAIT_RDYL;
            end
            PFPC_P_WAIT_RDYL:
               // device latched the phase
               if (!rdy_s2_ff)
               begin
                  if (rd_ff)
                  begin
                     oe_ff <= 1'b0;
                     state_ff <= PFPC_P_NOE;
                  end
                  else
                  begin
                     ncmd_ff <= 1'b1;
                     state_ff <= PFPC_P_WAIT_RDYH;
                  end
               end
               else if (tcnt_ff == 32'(TIMEOUT_CYC))
               begin
                  // a secured device never answers
                  ncmd_ff <= 1'b1;
                  tmo_ff <= 1'b1;
                  done_ff <= 1'b1;
                  state_ff <= PFPC_P_IDLE;
               end
               else
                  tcnt_ff <= tcnt_ff + 32'h1;
            PFPC_P_NOE:
            begin
               noe_ff <= 1'b0;
               state_ff <= PFPC_P_WAIT_NVL;
            end
            PFPC_P_WAIT_NVL:
               // data stands while valid is low
               if (!nv_s2_ff)
               begin
                  rsp_ff <= link.data;
                  noe_ff <= 1'b1;
                  state_ff <= PFPC_P_WAIT_NVH;
               end
            PFPC_P_WAIT_NVH:
               if (nv_s2_ff)
               begin
                  oe_ff <= 1'b1;
                  state_ff <= PFPC_P_NCMD_HI;
               end
            PFPC_P_NCMD_HI:
            begin
               ncmd_ff <= 1'b1;
               state_ff <= PFPC_P_WAIT_RDYH;
            end
            PFPC_P_WAIT_RDYH:
               if (rdy_s2_ff)
               begin
                  done_ff <= 1'b1;
                  state_ff <= PFPC_P_IDLE;
               end
            default:
               state_ff <= PFPC_P_IDLE;
         endcase
      end
   end

   assign link.ncmd = ncmd_ff;
   assign link.noe = noe_ff;
   assign link.mode = mode_ff;
   assign link.prog_data = pdata_ff;
   assign link.prog_data_oe = oe_ff;
   assign req_ready = ready_ff;
   assign rsp_done = done_ff;
   assign rsp_timeout = tmo_ff;
   assign rsp_data = rsp_ff;
endmodule : pfpc_prog

/* File: sim/pfpc_link_sva.sv */
// checker of the handshake rules seen on the programming link
module pfpc_link_sva #(
   parameter int DATA_W = 16
)(
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset, high
   input wire logic ncmd, // command strobe, low
   input wire logic noe, // read enable, low
   input wire logic prog_data_oe, // programmer drives data
   input wire logic rdy, // device ready
   input wire logic nvalid, // read data valid, low
   input wire logic [DATA_W-1:0] dev_data, // device data out
   input wire logic dev_data_oe, // device drives data
   input wire logic [DATA_W-1:0] data // resolved data wire
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // only one end may drive the shared wire
   bus_excl_a: assert property (!(prog_data_oe && dev_data_oe))
      else $error("both ends drive the data wire");
   // a phase is latched only while the strobe is low
   rdy_fall_a: assert property ($fell(rdy) |-> !ncmd)
      else $error("ready fell without a strobe");
   // ready returns only after the strobe has been high a while
   rdy_rise_a: assert property ($rose(rdy) |-> ncmd && $past(ncmd, 2))
      else $error("ready rose while strobe low");
   // valid read data is driven by the device alone
   valid_drive_a: assert property (!nvalid |->
      dev_data_oe && !rdy && !prog_data_oe && data == dev_data)
      else $error("valid read data not driven by device");
   // drive comes before valid
   valid_order_a: assert property ($fell(nvalid) |-> $past(dev_data_oe))
      else $error("valid before device drive");
   // read data holds while valid
   valid_stable_a: assert property (!nvalid ##1 !nvalid |-> $stable(dev_data))
      else $error("read data moved while valid");
   // device drives only after the read enable has settled low
   oe_noe_a: assert property ($rose(dev_data_oe) |-> !noe && !$past(noe, 2))
      else $error("device drove without read enable");
   // device lets go of the wire soon after read enable rises
   release_a: assert property ($rose(noe) |-> ##[1:5] !dev_data_oe)
      else $error("device kept driving after read");
   // an idle device neither drives nor flags data
   idle_quiet_a: assert property (rdy |-> nvalid && !dev_data_oe)
      else $error("idle device drives data");
endmodule : pfpc_link_sva

/* File: sim/parallel_flash_prog_commands_tb_top.sv */
// testbench: programmer end drives the device end over the link
module parallel_flash_prog_commands_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0; // system clock
   logic srst = 1'b1; // reset, high
   logic erase_pin = 1'b0; // erase pin
   logic tmode = 1'b0; // test mode pin
   logic req_valid = 1'b0; // request present
   logic req_read = 1'b0; // read handshake
   logic [3:0] req_mode = 4'h0; // phase code
   logic [15:0] req_data = 16'h0000; // write value
   logic req_ready, rsp_done, rsp_timeout; // programmer status
   logic [15:0] rsp_data; // read value
   logic mem_wr, mem_wr_flash, page_flush, erase_all, erase_abort;
   logic sel_ctl, secured; // selection and security
   logic [31:0] mem_addr; // write address
   logic [15:0] mem_wdata; // write data
   logic [1:0][15:0] lock_bits; // locks per controller
   logic [1:0][2:0] gp_bits; // gp bits per controller
   logic [31:0] wa[$]; // seen write addresses
   logic [16:0] wd[$]; // seen flash flag and data
   int error_cnt = 0, n_tests = 0, n_ab = 0, n_er = 0, n_pf = 0;
   always #4 clock = ~clock; // 125 MHz
   pfpc_if #(.DATA_W(16)) pfpc_if_i ();
   pfpc_dev #(.ERASE_HOLD_CYC(50)) pfpc_dev_i (.clock(clock), .srst(srst),
      .link(pfpc_if_i.dev), .erase_pin(erase_pin), .test_mode_input(tmode),
      .mem_wr(mem_wr), .mem_wr_flash(mem_wr_flash), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .page_flush(page_flush), .erase_all(erase_all),
      .erase_abort(erase_abort), .sel_ctl(sel_ctl), .secured(secured),
      .lock_bits(lock_bits), .gp_bits(gp_bits));
   pfpc_prog #(.TIMEOUT_CYC(20)) pfpc_prog_i (.clock(clock), .srst(srst),
      .link(pfpc_if_i.prog), .req_valid(req_valid), .req_read(req_read),
      .req_mode(req_mode), .req_data(req_data), .req_ready(req_ready),
      .rsp_done(rsp_done), .rsp_timeout(rsp_timeout), .rsp_data(rsp_data));
   pfpc_link_sva #(.DATA_W(16)) pfpc_link_sva_i (.clock(clock), .srst(srst),
      .ncmd(pfpc_if_i.ncmd), .noe(pfpc_if_i.noe),
      .prog_data_oe(pfpc_if_i.prog_data_oe), .rdy(pfpc_if_i.rdy),
      .nvalid(pfpc_if_i.nvalid), .dev_data(pfpc_if_i.dev_data),
      .dev_data_oe(pfpc_if_i.dev_data_oe), .data(pfpc_if_i.data));
   // record write strobes and count one-cycle pulses
   always @(posedge clock)
   begin
      if (mem_wr === 1'b1) wa.push_back(mem_addr);
      if (mem_wr === 1'b1) wd.push_back({mem_wr_flash, mem_wdata});
      n_ab += int'(erase_abort === 1'b1);
      n_er += int'(erase_all === 1'b1);
      n_pf += int'(page_flush === 1'b1);
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // one handshake through the programmer end, bounded waits
   task automatic hs(input logic rd, input logic [3:0] md,
                     input logic [15:0] d, input logic to);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 300) @(posedge clock) #1 n++;
      req_valid = 1'b1;
      req_read = rd;
      req_mode = md;
      req_data = d;
      @(posedge clock) #1 req_valid = 1'b0;
      while (rsp_done !== 1'b1 && n < 600) @(posedge clock) #1 n++;
      if (n >= 600)
      begin
         error_cnt++;
         tally_and_finish();
      end
      chk("timeout flag", 32'(to), 32'(rsp_timeout));
   endtask : hs
   // command phase then one write data phase
   task automatic cmd(input logic [7:0] op, input logic [15:0] d);
      hs(1'b0, pfpc_pkg::MODE_CMD, {8'h00, op}, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_DATA, d, 1'b0);
   endtask : cmd
   // command phase then one read data phase, judged
   task automatic rdc(input string nm, input logic [7:0] op,
                      input logic [15:0] e);
      hs(1'b0, pfpc_pkg::MODE_CMD, {8'h00, op}, 1'b0);
      hs(1'b1, pfpc_pkg::MODE_DATA, 16'h0000, 1'b0);
      chk(nm, 32'(e), 32'(rsp_data));
   endtask : rdc
   // command phase then both address phases, low part first
   task automatic hdr(input logic [7:0] op, input logic [31:0] a);
      hs(1'b0, pfpc_pkg::MODE_CMD, {8'h00, op}, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_ADDR, a[15:0], 1'b0);
      hs(1'b0, pfpc_pkg::MODE_ADDR + 4'h1, a[31:16], 1'b0);
   endtask : hdr
   task automatic t_lock();
      cmd(pfpc_pkg::OP_SLK, 16'h8001);
      rdc("lock mask", pfpc_pkg::OP_RLK, 16'h8001);
      cmd(pfpc_pkg::OP_ULK, 16'h0001);
      rdc("lock mask", pfpc_pkg::OP_RLK, 16'h8000);
   endtask : t_lock
   task automatic t_gp_erase();
      cmd(pfpc_pkg::OP_GPST, 16'h0005);
      rdc("gp mask", pfpc_pkg::OP_GPRD, 16'h0005);
      cmd(pfpc_pkg::OP_GPCL, 16'h0001);
      rdc("gp mask", pfpc_pkg::OP_GPRD, 16'h0004);
      cmd(pfpc_pkg::OP_ERA, 16'h0000);
      chk("aborts", 1, n_ab);
      chk("erases", 0, n_er);
      chk("locks kept", 32'h8000, 32'(lock_bits[0]));
      cmd(pfpc_pkg::OP_ULK, 16'hFFFF);
      cmd(pfpc_pkg::OP_ERA, 16'h0000);
      chk("erases", 1, n_er);
      chk("gp cleared", 0, 32'(gp_bits[0]));
   endtask : t_gp_erase
   task automatic t_sel();
      chk("default ctl", 0, 32'(sel_ctl));
      cmd(pfpc_pkg::OP_CSEL, 16'h0001);
      chk("ctl", 1, 32'(sel_ctl));
      cmd(pfpc_pkg::OP_SLK, 16'h0010);
      chk("ctl1 locks", 32'h0010, 32'(lock_bits[1]));
      chk("ctl0 locks", 0, 32'(lock_bits[0]));
      cmd(pfpc_pkg::OP_SEC, 16'h0000);
      chk("secured", 0, 32'(secured));
      cmd(pfpc_pkg::OP_CSEL, 16'h0000);
      chk("ctl", 0, 32'(sel_ctl));
   endtask : t_sel
   task automatic t_memory_write_cmd();
      int p0;
      hdr(pfpc_pkg::OP_MEMW, 32'h00011234);
      hs(1'b0, pfpc_pkg::MODE_DATA, 16'hAAAA, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_DATA, 16'h5555, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_ADDR, 16'h0010, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_ADDR + 4'h1, 16'h0000, 1'b0);
      hs(1'b0, pfpc_pkg::MODE_DATA, 16'h0F0F, 1'b0);
      hdr(pfpc_pkg::OP_WLK, 32'h00004000);
      hs(1'b0, pfpc_pkg::MODE_DATA, 16'h1111, 1'b0);
      p0 = n_pf;
      rdc("page lock", pfpc_pkg::OP_RLK, 16'h0002);
      chk("flushes", 1, n_pf - p0);
      chk("writes", 4, wa.size());
      chk("addr 0", 32'h00011234, wa[0]);
      chk("addr 1", 32'h00011235, wa[1]);
      chk("addr 2", 32'h00000010, wa[2]);
      chk("data 1", 32'h05555, 32'(wd[1]));
      chk("data 2", 32'h00F0F, 32'(wd[2]));
      chk("page data", 32'h11111, 32'(wd[3]));
   endtask : t_memory_write_cmd
   task automatic t_sec();
      rdc("version", pfpc_pkg::OP_VER, pfpc_pkg::VERSION_DEF);
      cmd(pfpc_pkg::OP_SEC, 16'h0000);
      chk("secured", 1, 32'(secured));
      hs(1'b0, pfpc_pkg::MODE_CMD, 16'h0023, 1'b1);
      tmode = 1'b1;
      erase_pin = 1'b1;
      repeat (70) @(posedge clock);
      #1 chk("secured", 1, 32'(secured));
      tmode = 1'b0;
      repeat (70) @(posedge clock);
      #1 chk("secured", 0, 32'(secured));
      erase_pin = 1'b0;
   endtask : t_sec
   // main sequence: reset, then each scenario
   initial
   begin
      repeat (10) @(posedge clock);
      #1 srst = 1'b0;
      t_lock();
      t_gp_erase();
      t_sel();
      t_memory_write_cmd();
      t_sec();
      tally_and_finish();
   end
endmodule : parallel_flash_prog_commands_tb_top
